// ### pdm_regs.svh
// Purpose: offsets, field positions, reset values and timing counts of the power-down controller
// Assumes: byte addressing on a 32-bit Avalon-MM slave
// Notes: included by the design module and the bench
`ifndef PDM_REGS_SVH
`define PDM_REGS_SVH

`define STBY_CTRL_OFFSET 28'h5FFFFBC
`define STBY_CTRL_RESET 8'h1F
`define STBY_SEL_BIT 7
`define PORT_FLOAT_BIT 6
`define STBY_RSVD_ZERO_BIT 5
`define STBY_RSVD_ONES 8'h1F
`define WDT_WAIT_DEFAULT 16'h0100

`endif

// ### pdm_pkg.sv
// Purpose: types for the power-down mode controller
// Assumes: nothing beyond the register header
// Notes: one state enumeration only
package pdm_pkg;
  typedef enum logic [2:0] {
    ST_RUN,
    ST_SLEEP,
    ST_STANDBY,
    ST_SETTLE
  } pdm_state_t;
endpackage

// ### power_down_mode_control.sv
// Purpose: sleep and standby control with clock gating, port hold/float and wake selection
// Assumes: 20 MHz ref_clk, synchronous active-low rst_n, Avalon-MM master with waitrequest
// Notes: clock gating is expressed as enable outputs; chip_init_pin is sampled synchronously
//
// Summary of operation
// - sleep instruction with standby select 0 enters sleep; system clock runs.
// - sleep instruction with standby select 1 enters standby; everything halts.
// - CPU stops right after sleep instruction; its registers are kept.
// - peripherals keep their clock in sleep; only the CPU stops.
// - an accepted interrupt ends sleep and starts interrupt exception processing.
// - interrupts at or below the CPU mask level do not end sleep.
// - interrupts disabled by their own peripheral do not end sleep.
// - DMA address error in sleep ends sleep and starts its exception.
// - reset pin low with NMI high leaves sleep into power-on reset.
// - rising NMI edge, when selected, raises NMI which ends sleep.
// - reset pin low with NMI low leaves sleep into manual reset.
// - falling NMI edge, when selected, raises NMI which ends sleep.
// - writing 1 to standby select is ignored while watchdog runs.
// - writing 1 to port-float select is ignored while watchdog runs.
// - port-float select: 0 holds ports in standby, 1 floats them.
// - standby control register resets to 1F, both select bits cleared.
// - bit 5 reads 0, bits 4 to 0 ignore writes and read 1.
// - standby ends only on NMI, power-on reset or manual reset.
// - NMI wake from standby clocks only watchdog until overflow, then NMI.
// - standby entry initialises some peripherals, keeps CPU, RAM and this register.
`timescale 1ns/1ps
`include "pdm_regs.svh"

module power_down_mode_control
  import pdm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [27:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sleep_exec,
  input wire logic watchdog_run_enable,
  input wire logic irq_request,
  input wire logic [3:0] irq_level,
  input wire logic irq_source_enable,
  input wire logic [3:0] cpu_mask_level,
  input wire logic dma_addr_error,
  input wire logic chip_init_pin,
  input wire logic nmi_pin,
  input wire logic nmi_edge_select,
  input wire logic watchdog_overflow,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic watchdog_clk_en,
  output logic port_hold,
  output logic port_float,
  output logic periph_standby_init,
  output logic irq_exception_start,
  output logic dma_error_exception_start,
  output logic nmi_exception_start,
  output logic power_on_reset_req,
  output logic manual_reset_req
);

  // ********************************
  // register bus
  // ********************************
  logic stby_sel_q, stby_sel_d;
  logic port_float_sel_q, port_float_sel_d;
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic hit;
  logic [7:0] reg_view;
  logic req;
  // sized copies of the register constants
  localparam logic [27:0] STBY_ADDR = `STBY_CTRL_OFFSET;
  localparam logic [7:0] STBY_RESET = `STBY_CTRL_RESET;
  localparam logic [7:0] RSVD_ONES = `STBY_RSVD_ONES;

  assign req = avs_read | avs_write;
  // word match only: the register sits in byte lane 0
  assign hit = (avs_address[27:2] == STBY_ADDR[27:2]);
  // bit 5 reads 0, bits 4..0 read 1
  assign reg_view = {stby_sel_q, port_float_sel_q, 1'b0, RSVD_ONES[4:0]};
  // one wait state: the master is answered on the edge after it is seen
  assign avs_waitrequest = req & ~ack_q;

  // ********************************
  // register bus handshake
  // ********************************
  always_comb begin
    ack_d = req & ~ack_q;
    rdata_d = rdata_q;
    if (avs_read && !ack_q) begin
      // unmapped words read as zero
      rdata_d = 32'h0000_0000;
      if (hit) begin
        rdata_d = {24'h000000, reg_view};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata = rdata_q;

  // ********************************
  // register fields
  // ********************************
  // a write lands on the edge at which the master sees waitrequest low
  always_comb begin
    stby_sel_d = stby_sel_q;
    port_float_sel_d = port_float_sel_q;
    if (avs_write && ack_q && hit && avs_byteenable[0]) begin
      // a 1 cannot be written while the watchdog runs
      if (!(avs_writedata[`STBY_SEL_BIT] && watchdog_run_enable)) begin
        stby_sel_d = avs_writedata[`STBY_SEL_BIT];
      end
      // same lock for port float
      if (!(avs_writedata[`PORT_FLOAT_BIT] && watchdog_run_enable)) begin
        port_float_sel_d = avs_writedata[`PORT_FLOAT_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      // reset image 1F: both selects cleared
      stby_sel_q <= STBY_RESET[`STBY_SEL_BIT];
      port_float_sel_q <= STBY_RESET[`PORT_FLOAT_BIT];
    end else begin
      stby_sel_q <= stby_sel_d;
      port_float_sel_q <= port_float_sel_d;
    end
  end

  // ********************************
  // wake qualification
  // ********************************
  logic nmi_q;
  logic nmi_edge;
  logic irq_wake;
  logic init_low;

  // nmi edge as selected
  assign nmi_edge = nmi_edge_select ? (nmi_pin & ~nmi_q) : (~nmi_pin & nmi_q);
  // accepted only above mask and enabled at source
  assign irq_wake = irq_request & irq_source_enable & (irq_level > cpu_mask_level);
  // the reset pin is active low and taken as synchronous
  assign init_low = ~chip_init_pin;

  // loaded in reset as well, so no false edge follows reset
  always_ff @(posedge ref_clk) begin
    nmi_q <= nmi_pin;
  end

  // ********************************
  // mode sequencer
  // ********************************
  pdm_state_t state_q, state_d;
  // exception and reset requests leave as one-cycle pulses
  logic irq_x_d, dma_x_d, nmi_x_d, por_d, mr_d, pinit_d;
  logic irq_x_q, dma_x_q, nmi_x_q, por_q, mr_q, pinit_q;

  always_comb begin
    state_d = state_q;
    irq_x_d = 1'b0;
    dma_x_d = 1'b0;
    nmi_x_d = 1'b0;
    por_d = 1'b0;
    mr_d = 1'b0;
    pinit_d = 1'b0;
    unique case (state_q)
      ST_RUN: begin
        // the select bit chooses the mode at the moment of the instruction
        if (sleep_exec) begin
          if (stby_sel_q) begin
            state_d = ST_STANDBY;
            pinit_d = 1'b1;
          end else begin
            state_d = ST_SLEEP;
          end
        end
      end
      ST_SLEEP: begin
        // released on the edge after detection
        // priority: reset pin, then nmi edge, then dma error, then interrupt
        if (init_low) begin
          state_d = ST_RUN;
          por_d = nmi_pin;
          mr_d = ~nmi_pin;
        end else if (nmi_edge) begin
          state_d = ST_RUN;
          nmi_x_d = 1'b1;
        end else if (dma_addr_error) begin
          state_d = ST_RUN;
          dma_x_d = 1'b1;
        end else if (irq_wake) begin
          state_d = ST_RUN;
          irq_x_d = 1'b1;
        end
      end
      ST_STANDBY: begin
        // only nmi or reset pin wake standby
        if (init_low) begin
          state_d = ST_RUN;
          por_d = nmi_pin;
          mr_d = ~nmi_pin;
        end else if (nmi_edge) begin
          state_d = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        // the reset pin still wins while the oscillator settles
        if (init_low) begin
          state_d = ST_RUN;
          por_d = nmi_pin;
          mr_d = ~nmi_pin;
        end else if (watchdog_overflow) begin
          state_d = ST_RUN;
          nmi_x_d = 1'b1;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= ST_RUN;
      irq_x_q <= 1'b0;
      dma_x_q <= 1'b0;
      nmi_x_q <= 1'b0;
      por_q <= 1'b0;
      mr_q <= 1'b0;
      pinit_q <= 1'b0;
    end else begin
      state_q <= state_d;
      irq_x_q <= irq_x_d;
      dma_x_q <= dma_x_d;
      nmi_x_q <= nmi_x_d;
      por_q <= por_d;
      mr_q <= mr_d;
      pinit_q <= pinit_d;
    end
  end

  // ********************************
  // clock enables and ports
  // ********************************
  // gating is shown as enables; each mode opens only its own clocks
  always_comb begin
    cpu_clk_en = 1'b0;
    periph_clk_en = 1'b0;
    watchdog_clk_en = 1'b1;
    port_hold = 1'b0;
    port_float = 1'b0;
    unique case (state_q)
      ST_RUN: begin
        cpu_clk_en = 1'b1;
        periph_clk_en = 1'b1;
      end
      ST_SLEEP: begin
        // cpu halted, peripherals keep their clock
        periph_clk_en = 1'b1;
      end
      ST_STANDBY: begin
        // oscillator stopped: even the watchdog waits
        watchdog_clk_en = 1'b0;
        port_hold = !port_float_sel_q;
        port_float = port_float_sel_q;
      end
      ST_SETTLE: begin
        // only the watchdog is clocked until it overflows
        port_hold = !port_float_sel_q;
        port_float = port_float_sel_q;
      end
      default: begin
        cpu_clk_en = 1'b0;
      end
    endcase
  end

  // ********************************
  // exception and reset requests
  // ********************************
  // one-cycle pulses, registered in the sequencer
  assign periph_standby_init = pinit_q;
  assign irq_exception_start = irq_x_q;
  assign dma_error_exception_start = dma_x_q;
  assign nmi_exception_start = nmi_x_q;
  assign power_on_reset_req = por_q;
  assign manual_reset_req = mr_q;

endmodule

// ### wdt_model.sv
// Purpose: watchdog stand-in that times oscillator settling
// Assumes: counts only while its clock runs and peripherals are stopped
// Notes: overflow is a one-cycle pulse
`timescale 1ns/1ps
module wdt_model #(parameter int WAIT = 6) (
  input logic ref_clk,
  input logic rst_n,
  input logic watchdog_clk_en,
  input logic periph_clk_en,
  output logic watchdog_overflow
);
  int cnt_q;
  wire run = rst_n && watchdog_clk_en && !periph_clk_en;
  always_ff @(posedge ref_clk) begin
    cnt_q <= run ? cnt_q + 1 : 0;
    watchdog_overflow <= run && cnt_q == WAIT - 1;
  end
endmodule

// ### pdm_monitor.sv
// Purpose: port checks for power_down_mode_control
// Assumes: one clock, synchronous active-low reset
// Notes: attached by the bind below
`timescale 1ns/1ps
module pdm_monitor (
  input logic ref_clk,
  input logic rst_n,
  input logic sleep_exec,
  input logic irq_request,
  input logic [3:0] irq_level,
  input logic irq_source_enable,
  input logic [3:0] cpu_mask_level,
  input logic dma_addr_error,
  input logic chip_init_pin,
  input logic nmi_pin,
  input logic nmi_edge_select,
  input logic cpu_clk_en,
  input logic periph_clk_en,
  input logic watchdog_clk_en,
  input logic irq_exception_start,
  input logic dma_error_exception_start,
  input logic nmi_exception_start,
  input logic power_on_reset_req,
  input logic manual_reset_req
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire slp = !cpu_clk_en && periph_clk_en;
  wire calm = chip_init_pin && !dma_addr_error;
  wire irq_ok = irq_request && irq_source_enable && irq_level > cpu_mask_level;
  sleep_in_a: assert property (cpu_clk_en && sleep_exec |=> !cpu_clk_en)
    else $error("cpu clock kept");
  irq_wake_a: assert property (slp && calm && $stable(nmi_pin) && irq_ok
    |=> irq_exception_start && cpu_clk_en) else $error("irq did not wake");
  irq_hold_a: assert property (slp && calm && $stable(nmi_pin) && !irq_ok
    |=> !cpu_clk_en) else $error("sleep left early");
  dma_wake_a: assert property (slp && chip_init_pin && dma_addr_error && $stable(nmi_pin)
    |=> dma_error_exception_start && cpu_clk_en) else $error("dma error ignored");
  por_req_a: assert property (!cpu_clk_en && $fell(chip_init_pin) && nmi_pin
    |=> power_on_reset_req) else $error("no power-on reset");
  manual_req_a: assert property (!cpu_clk_en && $fell(chip_init_pin) && !nmi_pin
    |=> manual_reset_req) else $error("no manual reset");
  nmi_wake_a: assert property (slp && chip_init_pin
    && (nmi_edge_select ? $rose(nmi_pin) : $fell(nmi_pin)) |=> nmi_exception_start)
    else $error("nmi missed");
  standby_keep_a: assert property (!watchdog_clk_en && chip_init_pin && $stable(nmi_pin)
    |=> !cpu_clk_en && !periph_clk_en) else $error("standby left early");
endmodule
bind power_down_mode_control pdm_monitor u_pdm_monitor (.*);

// ### tb.sv
// Purpose: self-checking bench for power_down_mode_control
// Assumes: 20 MHz clock, Avalon-MM slave with waitrequest
// Notes: wdt_model supplies the settling overflow
`timescale 1ns/1ps
`include "pdm_regs.svh"
module tb;
  logic ref_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, sleep_exec = 0, irq_request = 0;
  logic watchdog_run_enable = 0, irq_source_enable = 1, dma_addr_error = 0, chip_init_pin = 1;
  logic nmi_pin = 0, nmi_edge_select = 0, avs_waitrequest, cpu_clk_en, periph_clk_en;
  logic watchdog_clk_en, port_hold, port_float, periph_standby_init, irq_exception_start;
  logic dma_error_exception_start, nmi_exception_start, power_on_reset_req, manual_reset_req;
  logic watchdog_overflow;
  logic [3:0] irq_level = 0, cpu_mask_level = 4'h3, avs_byteenable = 4'h1;
  logic [27:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, q;
  wire [3:0] pulses = {dma_error_exception_start, nmi_exception_start,
    power_on_reset_req, manual_reset_req};
  localparam logic [27:0] adr = `STBY_CTRL_OFFSET;
  int bad_count = 0, checks_done = 0;
  always #25 ref_clk = ~ref_clk;
  power_down_mode_control u_power_down_mode_control (.*);
  wdt_model u_wdt_model (.*);
  // ****************
  // shared tasks
  // ****************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [27:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    q = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    @(posedge ref_clk);
  endtask
  task automatic rst;
    rst_n <= 0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1;
    @(posedge ref_clk);
  endtask
  task automatic go(input logic [7:0] sel);
    bus(1, adr, sel);
    sleep_exec <= 1;
    @(posedge ref_clk);
    sleep_exec <= 0;
    @(posedge ref_clk);
  endtask
  task automatic t_reg;
    bus(0, adr, 0);
    chk("reset", 32'h1F, q);
    bus(0, adr - 28'h4, 0);
    chk("unmapped", 32'h0, q);
    watchdog_run_enable <= 1;
    bus(1, adr, 8'hFF);
    bus(0, adr, 0);
    chk("locked", 32'h1F, q);
    watchdog_run_enable <= 0;
    bus(1, adr, 8'hC0);
    bus(0, adr, 0);
    chk("open", 32'hDF, q);
  endtask
  task automatic t_sleep;
    go(8'h0);
    chk("sleep", 32'h1, {cpu_clk_en, periph_clk_en});
    chk("no init", 32'h0, periph_standby_init);
    irq_request <= 1;
    irq_level <= 4'h3;
    repeat (2) @(posedge ref_clk);
    chk("masked", 32'h1, {cpu_clk_en, periph_clk_en});
    irq_level <= 4'h4;
    irq_source_enable <= 0;
    repeat (2) @(posedge ref_clk);
    chk("disabled", 32'h1, {cpu_clk_en, periph_clk_en});
    irq_source_enable <= 1;
    repeat (2) @(posedge ref_clk);
    chk("irq wake", 32'h3, {irq_exception_start, cpu_clk_en});
    irq_request <= 0;
  endtask
  task automatic t_wake;
    for (int k = 0; k < 5; k++) begin
      nmi_edge_select <= (k == 1);
      nmi_pin <= (k == 2 || k == 3);
      go(8'h0);
      dma_addr_error <= (k == 0);
      if (k > 2) chip_init_pin <= 0;
      else if (k > 0) nmi_pin <= (k == 1);
      repeat (2) @(posedge ref_clk);
      chk("wake", 32'h8 >> (k - (k > 1)), pulses);
      dma_addr_error <= 0;
      chip_init_pin <= 1;
      rst;
    end
  endtask
  task automatic t_stby;
    for (int k = 0; k < 2; k++) begin
      nmi_edge_select <= k[0];
      nmi_pin <= !k[0];
      go(k ? 8'hC0 : 8'h80);
      chk("standby", 32'h2 - k, {cpu_clk_en, periph_clk_en, watchdog_clk_en, port_hold,
        port_float});
      chk("init pulse", 32'h1, periph_standby_init);
      irq_request <= 1;
      irq_level <= 4'hF;
      dma_addr_error <= 1;
      repeat (3) @(posedge ref_clk);
      chk("held", 32'h0, {cpu_clk_en, periph_clk_en});
      irq_request <= 0;
      dma_addr_error <= 0;
      nmi_pin <= k[0];
      repeat (40) if (cpu_clk_en !== 1'b1) @(posedge ref_clk);
      chk("nmi exit", 32'h3, {cpu_clk_en, nmi_exception_start});
      bus(0, adr, 0);
      chk("kept", k ? 32'hDF : 32'h9F, q);
    end
  endtask
  task automatic t_stby_init;
    nmi_edge_select <= 0;
    nmi_pin <= 1;
    go(8'h80);
    chip_init_pin <= 0;
    repeat (2) @(posedge ref_clk);
    chk("standby reset", 32'h5, {pulses, cpu_clk_en});
    chip_init_pin <= 1;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    rst;
    t_reg;
    t_sleep;
    t_wake;
    t_stby;
    t_stby_init;
    wrap_up;
  end
  initial begin
    repeat (4000) @(posedge ref_clk);
    bad_count++;
    wrap_up;
  end
endmodule
